// ==== core/srm_pkg.sv ====
package srm_pkg;

	// Clock and documented time figures.
	localparam int CLK_HZ       = 100_000_000;
	localparam int MS_CYC       = CLK_HZ / 1000;
	localparam int ALIGN_BC_MS  = 50;
	localparam int ALIGN_B_MS   = 550;
	localparam int START_MS     = 1000;
	localparam int ALIGN_BC_DEF = ALIGN_BC_MS * MS_CYC;
	localparam int ALIGN_B_DEF  = ALIGN_B_MS * MS_CYC;
	localparam int START_DEF    = START_MS * MS_CYC;
	localparam int PWM_CYC_DEF  = 1000;
	localparam int TMR_W        = 27;

	// Data widths and fixed point.
	localparam int MW       = 12;
	localparam int DW       = 11;
	localparam int FW       = 24;
	localparam int RW       = 16;
	localparam int DUTY_SH  = 10;
	localparam int RES_FRAC = 8;
	localparam logic [DW-1:0] DUTY_FULL = 11'h400;
	localparam logic [DW-1:0] CC_STEP   = 11'h008;

	// Speed limits in rpm: 600, 1600 and 2600.
	localparam logic [MW-1:0] MIN_RPM    = 12'h258;
	localparam logic [MW-1:0] MAX_LO_RPM = 12'h640;
	localparam logic [MW-1:0] MAX_HI_RPM = 12'hA28;
	localparam logic [MW-1:0] UPDN_STEP  = 12'h064;
	localparam logic [MW-1:0] RAMP_STEP  = 12'h001;
	localparam logic [7:0]    RAMP_DIV   = 8'h64;
	localparam int            SPEED_K    = 500_000;

	// Current loop and commutation angle scaling.
	localparam logic [MW-1:0] I_MIN    = 12'h040;
	localparam logic [MW-1:0] I_MAX    = 12'hC00;
	localparam logic [MW-1:0] I_ALIGN  = 12'h200;
	localparam logic [MW-1:0] I_ZERO   = 12'h010;
	localparam int            KP_SH    = 2;
	localparam int            ANG_BASE = 512;
	localparam int            ANG_S_SH = 3;
	localparam int            ANG_I_SH = 4;
	localparam int            ANG_V_SH = 5;
	localparam int            ANG_SH   = 4;
	localparam logic [RW-1:0] RES_DEF  = 16'h0100;
	localparam int            RES_STEP_DIV = 1000;

	// Mains classification in volts, band -15 % to +10 %.
	localparam int NOM_LO_V   = 115;
	localparam int NOM_HI_V   = 230;
	localparam int TOL_LO_PCT = 85;
	localparam int TOL_HI_PCT = 110;
	localparam int MAINS_SPLIT = (NOM_LO_V + NOM_HI_V) / 2;
	localparam int LO_MIN_V = (NOM_LO_V * TOL_LO_PCT + 99) / 100;
	localparam int LO_MAX_V = NOM_LO_V * TOL_HI_PCT / 100;
	localparam int HI_MIN_V = (NOM_HI_V * TOL_LO_PCT + 99) / 100;
	localparam int HI_MAX_V = NOM_HI_V * TOL_HI_PCT / 100;
	localparam logic [MW-1:0] UV_LIM = 12'h0100;
	localparam logic [MW-1:0] OT_LIM = 12'h0C00;

	// Register offsets and control bits.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_SPEED  = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_MEAS   = 8'h0C;
	localparam logic [7:0] REG_RES    = 8'h10;
	localparam int CTRL_HOST  = 0;
	localparam int CTRL_START = 1;

	// Phase codes and rotation order.
	localparam logic [1:0] PH_A = 2'h0;
	localparam logic [1:0] PH_B = 2'h1;
	localparam logic [1:0] PH_C = 2'h2;

	typedef enum logic [2:0] {
		ST_INIT  = 3'b000,
		ST_IDLE  = 3'b001,
		ST_AL_BC = 3'b010,
		ST_AL_B  = 3'b011,
		ST_RES   = 3'b100,
		ST_RUN   = 3'b101,
		ST_FAULT = 3'b110
	} srm_state_t;

	typedef struct packed {
		logic [MW-1:0]        line_v;
		logic [MW-1:0]        dcbus_v;
		logic [MW-1:0]        temp;
		logic [2:0][MW-1:0]   ph_cur;
	} srm_meas_t;

	typedef struct packed {
		logic mains;
		logic uv;
		logic ot;
		logic hw;
	} srm_fault_t;

endpackage : srm_pkg

// ==== core/srm_pwm_unit.sv ====
`timescale 1ns/100ps
module srm_pwm_unit
	import srm_pkg::*;
#(
	parameter int PERIOD = PWM_CYC_DEF
) (
	// Clock and reset.
	input  wire logic                 sys_clk_i,
	input  wire logic                 rstn_i,
	// Duty per phase and enable.
	input  wire logic                 en_i,
	input  wire logic [2:0][DW-1:0]   duty_i,
	// Hardware fault inputs.
	input  wire logic                 oc_i,
	input  wire logic                 ov_i,
	// Outputs.
	output logic                      tick_o,
	output logic                      hw_flt_o,
	output logic [2:0]                pwm_o
);

	typedef struct packed {
		logic [15:0] cnt;
		logic [2:0]  pwm;
		logic        tick;
		logic        hw;
	} srm_pwm_st_t;

	srm_pwm_st_t s;
	srm_pwm_st_t n;
	logic [2:0]  cmp;

	// One comparator per phase against the period counter.
	for (genvar k = 0; k < 3; k++) begin : g_ph
		logic [31:0] thr;
		assign thr    = (32'(duty_i[k]) * 32'(PERIOD)) >> DUTY_SH;
		assign cmp[k] = 32'(s.cnt) < thr;
	end

	// Counter wraps at the period and marks each start with a tick.
	always_comb begin
		n      = s;
		n.tick = 1'b0;
		if (s.cnt == 16'(PERIOD - 1)) begin
			n.cnt  = '0;
			n.tick = 1'b1;
		end else begin
			n.cnt = s.cnt + 16'h0001;
		end
		n.pwm = en_i ? cmp : 3'b000;
		n.hw  = oc_i | ov_i;
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Raw fault pins cut the outputs with no clock in the path.
	assign pwm_o    = s.pwm & {3{en_i & ~oc_i & ~ov_i}};
	assign tick_o   = s.tick;
	assign hw_flt_o = s.hw;

endmodule : srm_pwm_unit

// ==== core/srm_drive_seq.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - After reset initialise, then manual mode.
// - Host mode taken only while motor stopped.
// - Start on active source command, no fault.
// - Flux estimate updated per PWM period, compared.
// - Angle from desired speed, current, bus voltage.
// - Flux over reference: next phase, same update.
// - New phase runs full duty first.
// - Current over demand hands duty to controller.
// - Speed from time between commutations.
// - Ramped reference; speed error sets current.
// - Reference clamped, maximum depends on mains.
// - Overcurrent, overvoltage on PWM fault pins.
// - Mains measured once, classed low or high.
// - Out of band mains raises blocking fault.
// - Any fault disables PWM outputs immediately.
// - Fault exit needs clear and stop; lamp lit.
// - Align: B and C, then B alone.
// - Start resistance: sum of volts over amps.
// - Alignment plus measurement take fixed time.
// - Run starts: B off, A on.
// - Alignment repeated on every start.
// - Discharge flux error trims resistance 0.1 percent.
module srm_drive_seq
	import srm_pkg::*;
#(
	parameter int ALIGN_BC_CYC = ALIGN_BC_DEF,
	parameter int ALIGN_B_CYC  = ALIGN_B_DEF,
	parameter int START_CYC    = START_DEF,
	parameter int PWM_CYC      = PWM_CYC_DEF
) (
	// Clock and reset.
	input  wire logic         sys_clk_i,
	input  wire logic         rstn_i,
	// Register port.
	input  wire logic [7:0]   reg_addr_i,
	input  wire logic [31:0]  reg_wdata_i,
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	output logic [31:0]       reg_rdata_o,
	// Manual panel.
	input  wire logic         run_stop_i,
	input  wire logic         up_i,
	input  wire logic         down_i,
	output logic              led_o,
	// Measurements and power stage.
	input  wire srm_meas_t    meas_i,
	input  wire logic         hw_oc_i,
	input  wire logic         hw_ov_i,
	output logic [2:0]        pwm_o
);

	localparam logic [TMR_W-1:0] T_BC  = TMR_W'(ALIGN_BC_CYC - 1);
	localparam logic [TMR_W-1:0] T_B   = TMR_W'(ALIGN_B_CYC - 1);
	localparam logic [TMR_W-1:0] T_RES =
		TMR_W'(START_CYC - ALIGN_BC_CYC - ALIGN_B_CYC - 1);

	typedef struct packed {
		srm_state_t        st;
		logic              host;
		logic              host_start;
		logic [MW-1:0]     host_spd;
		logic [MW-1:0]     man_spd;
		logic              up_q;
		logic              dn_q;
		logic              mains_hi;
		logic              mains_flt;
		logic [TMR_W-1:0]  tmr;
		logic [1:0]        ph;
		logic [1:0]        ph_off;
		logic              dis;
		logic [2:0]        en;
		logic              full;
		logic [DW-1:0]     duty;
		logic [FW-1:0]     flux;
		logic [FW-1:0]     dflux;
		logic [FW-1:0]     err_f;
		logic [RW-1:0]     res;
		logic [31:0]       sum_u;
		logic [31:0]       sum_i;
		logic [MW-1:0]     spd_ref;
		logic [MW-1:0]     spd_meas;
		logic [15:0]       per;
		logic [MW-1:0]     i_des;
		logic [7:0]        ramp;
		logic [31:0]       rdata;
	} srm_seq_t;

	srm_seq_t            s;
	srm_seq_t            n;
	logic                tick;
	logic                hw_flt;
	logic [2:0][DW-1:0]  duty_v;
	logic [DW-1:0]       duty_eff;
	logic [MW-1:0]       cur_on;
	logic [MW-1:0]       cur_off;
	logic signed [FW-1:0] u_ph;
	logic signed [FW-1:0] ir_on;
	logic signed [FW-1:0] ir_off;
	logic signed [FW-1:0] flux_nx;
	logic signed [FW-1:0] flux_ref;
	logic signed [FW-1:0] dflux_nx;
	logic signed [FW-1:0] err_nx;
	logic [MW-1:0]       angle;
	logic [MW-1:0]       spd_max;
	logic [MW-1:0]       cmd_raw;
	logic [MW-1:0]       cmd;
	logic signed [MW:0]  spd_err;
	logic [31:0]         i_calc;
	logic [31:0]         spd_q;
	logic [47:0]         r0_q;
	logic [RW-1:0]       r0;
	logic [RW-1:0]       res_step;
	logic [1:0]          ph_next;
	logic                start_cmd;
	logic                stopped;
	logic                running;
	srm_fault_t          flt;

	// Phase voltage is duty times bus voltage; drop is current times R.
	assign duty_eff = s.full ? DUTY_FULL : s.duty;
	assign cur_on   = meas_i.ph_cur[s.ph];
	assign cur_off  = meas_i.ph_cur[s.ph_off];
	assign u_ph     = FW'((32'(duty_eff) * 32'(meas_i.dcbus_v)) >> DUTY_SH);
	assign ir_on    = FW'((32'(cur_on) * 32'(s.res)) >> RES_FRAC);
	assign ir_off   = FW'((32'(cur_off) * 32'(s.res)) >> RES_FRAC);
	assign flux_nx  = $signed(s.flux) + u_ph - ir_on;
	assign dflux_nx = $signed(s.dflux) - $signed(FW'(meas_i.dcbus_v)) - ir_off;
	assign err_nx   = $signed(s.err_f)
		+ (($signed(s.dflux) - $signed(s.err_f)) >>> 2);

	// Angle grows with speed and current, shrinks with bus voltage.
	assign angle = MW'(ANG_BASE + 32'(s.spd_ref >> ANG_S_SH)
		+ 32'(s.i_des >> ANG_I_SH)
		- 32'(meas_i.dcbus_v >> ANG_V_SH));
	// Reference is linear in current for the chosen angle.
	assign flux_ref = FW'((32'(cur_on) * 32'(angle)) >> ANG_SH);

	// Commanded speed from the active source, limited by mains.
	assign spd_max = s.mains_hi ? MAX_HI_RPM : MAX_LO_RPM;
	assign cmd_raw = s.host ? s.host_spd : s.man_spd;
	assign cmd = (cmd_raw < MIN_RPM) ? MIN_RPM :
		(cmd_raw > spd_max) ? spd_max : cmd_raw;

	// Speed error drives the current demand.
	assign spd_err = $signed({1'b0, s.spd_ref})
		- $signed({1'b0, s.spd_meas});
	assign i_calc = 32'(I_MIN) + (32'(spd_err[MW-1:0]) << KP_SH);

	// Speed is a constant over the commutation interval.
	assign spd_q = (s.per == 16'h0000) ? 32'h0000_0000 :
		32'(SPEED_K) / 32'(s.per);

	// Start resistance; falls back to nominal on empty sums.
	assign r0_q = (s.sum_i == 32'h0000_0000) ? 48'(RES_DEF) :
		(48'(s.sum_u) << RES_FRAC) / 48'(s.sum_i);
	assign r0 = (r0_q > 48'(16'hFFFF)) ? 16'hFFFF : r0_q[RW-1:0];
	assign res_step = RW'(32'(s.res) / 32'(RES_STEP_DIV));

	assign ph_next = (s.ph == PH_C) ? PH_A : s.ph + 2'h1;
	assign start_cmd = s.host ? s.host_start : run_stop_i;
	assign running = (s.st == ST_AL_BC) || (s.st == ST_AL_B)
		|| (s.st == ST_RES) || (s.st == ST_RUN);
	assign stopped = !running;

	// Software checks use bus measurements; pins go through the PWM unit.
	assign flt.mains = s.mains_flt;
	assign flt.uv    = meas_i.dcbus_v < UV_LIM;
	assign flt.ot    = meas_i.temp > OT_LIM;
	assign flt.hw    = hw_flt;

	// Next-state logic for the whole sequencer.
	always_comb begin
		n       = s;
		n.rdata = '0;
		n.up_q  = up_i;
		n.dn_q  = down_i;
		// Buttons step the manual speed on their rising edge.
		if (up_i && !s.up_q && s.man_spd < MAX_HI_RPM) begin
			n.man_spd = s.man_spd + UPDN_STEP;
		end
		if (down_i && !s.dn_q && s.man_spd > MIN_RPM) begin
			n.man_spd = s.man_spd - UPDN_STEP;
		end
		// Register writes.
		if (reg_wr_i) begin
			case (reg_addr_i)
				REG_CTRL: begin
					if (!reg_wdata_i[CTRL_HOST]) begin
						n.host = 1'b0;
					end else if (stopped) begin
						n.host = 1'b1;
					end
					n.host_start = reg_wdata_i[CTRL_START];
				end
				REG_SPEED: n.host_spd = reg_wdata_i[MW-1:0];
				default: ;
			endcase
		end
		// Register reads answer in the next cycle only.
		if (reg_rd_i) begin
			case (reg_addr_i)
				REG_CTRL:   n.rdata = {30'h0, s.host_start, s.host};
				REG_SPEED:  n.rdata = {20'h0, s.host_spd};
				REG_STATUS: n.rdata = {23'h0, s.mains_hi, flt, s.host,
					s.st};
				REG_MEAS:   n.rdata = {4'h0, s.spd_ref, 4'h0, s.spd_meas};
				REG_RES:    n.rdata = {4'h0, s.i_des, s.res};
				default:    n.rdata = '0;
			endcase
		end
		// Current control once per period on the powered phase.
		if (tick && running) begin
			if (s.full) begin
				n.full = !(cur_on > s.i_des);
				n.duty = DUTY_FULL;
			end else if (cur_on > s.i_des) begin
				n.duty = (s.duty > CC_STEP) ? s.duty - CC_STEP : '0;
			end else begin
				n.duty = (s.duty < DUTY_FULL - CC_STEP) ?
					s.duty + CC_STEP : DUTY_FULL;
			end
		end
		// Sequencer states.
		case (s.st)
			ST_INIT: begin
				// A single sample of the line classifies the supply.
				n.mains_hi = meas_i.line_v > MW'(MAINS_SPLIT);
				if (meas_i.line_v > MW'(MAINS_SPLIT)) begin
					n.mains_flt = meas_i.line_v < MW'(HI_MIN_V)
						|| meas_i.line_v > MW'(HI_MAX_V);
				end else begin
					n.mains_flt = meas_i.line_v < MW'(LO_MIN_V)
						|| meas_i.line_v > MW'(LO_MAX_V);
				end
				n.host = 1'b0;
				n.st   = ST_IDLE;
			end
			ST_IDLE: begin
				n.en = 3'b000;
				if (start_cmd && flt == '0) begin
					// Start values are reloaded; err_f and duty carry over from an earlier run.
					n.st    = ST_AL_BC;
					n.tmr   = '0;
					n.ph    = PH_B;
					n.en    = 3'b110;
					n.full  = 1'b1;
					n.i_des = I_ALIGN;
					n.sum_u = '0;
					n.sum_i = '0;
					n.res   = RES_DEF;
					n.dis   = 1'b0;
				end
			end
			ST_AL_BC: begin
				n.tmr = s.tmr + 1'b1;
				if (s.tmr == T_BC) begin
					n.st  = ST_AL_B;
					n.tmr = '0;
					n.en  = 3'b010;
				end
			end
			ST_AL_B: begin
				n.tmr = s.tmr + 1'b1;
				if (s.tmr == T_B) begin
					n.st  = ST_RES;
					n.tmr = '0;
				end
			end
			ST_RES: begin
				n.tmr = s.tmr + 1'b1;
				if (tick) begin
					n.sum_u = s.sum_u + 32'(u_ph);
					n.sum_i = s.sum_i + 32'(cur_on);
				end
				if (s.tmr == T_RES) begin
					// Total from alignment start is the fixed start time.
					n.st       = ST_RUN;
					n.res      = r0;
					n.ph       = PH_A;
					n.en       = 3'b001;
					n.full     = 1'b1;
					n.flux     = '0;
					n.per      = '0;
					n.spd_ref  = MIN_RPM;
					n.spd_meas = '0;
					n.ramp     = '0;
				end
			end
			ST_RUN: begin
				if (tick) begin
					n.per  = (s.per == 16'hFFFF) ? s.per : s.per + 16'h0001;
					n.flux = flux_nx;
					// Reference ramps toward command in bounded steps.
					n.ramp = (s.ramp == RAMP_DIV - 8'h01) ? '0 :
						s.ramp + 8'h01;
					if (s.ramp == RAMP_DIV - 8'h01) begin
						if (s.spd_ref < cmd) begin
							n.spd_ref = s.spd_ref + RAMP_STEP;
						end else if (s.spd_ref > cmd) begin
							n.spd_ref = s.spd_ref - RAMP_STEP;
						end
					end
					if (spd_err <= 0) begin
						n.i_des = I_MIN;
					end else begin
						n.i_des = (i_calc > 32'(I_MAX)) ? I_MAX :
							i_calc[MW-1:0];
					end
					// Discharge of the last phase integrates to zero current.
					if (s.dis) begin
						if (cur_off <= I_ZERO) begin
							n.dis   = 1'b0;
							n.err_f = err_nx;
							if ($signed(err_nx) > 0) begin
								n.res = s.res + res_step;
							end else begin
								n.res = s.res - res_step;
							end
						end else begin
							n.dflux = dflux_nx;
						end
					end
					if (flux_nx > flux_ref) begin
						// Off and on happen in the same update.
						n.ph       = ph_next;
						n.ph_off   = s.ph;
						n.en       = 3'b001 << ph_next;
						n.full     = 1'b1;
						n.flux     = '0;
						n.dflux    = flux_nx;
						n.dis      = 1'b1;
						n.per      = '0;
						n.spd_meas = (spd_q > 32'h0000_0FFF) ? 12'hFFF :
							spd_q[MW-1:0];
					end
				end
			end
			ST_FAULT: begin
				n.en = 3'b000;
				if (flt == '0 && !run_stop_i) begin
					n.st = ST_IDLE;
				end
			end
			default: n.st = ST_INIT;
		endcase
		// Losing the start command stops the drive.
		if (running && !start_cmd) begin
			n.st = ST_IDLE;
			n.en = 3'b000;
		end
		// Any fault outside ST_INIT overrides the sequence.
		if (flt != '0 && s.st != ST_INIT) begin
			n.st = ST_FAULT;
			n.en = 3'b000;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Only energised phases receive duty.
	for (genvar k = 0; k < 3; k++) begin : g_duty
		assign duty_v[k] = s.en[k] ? duty_eff : '0;
	end

	srm_pwm_unit #(
		.PERIOD (PWM_CYC)
	) u_pwm (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.en_i      (running && flt == '0),
		.duty_i    (duty_v),
		.oc_i      (hw_oc_i),
		.ov_i      (hw_ov_i),
		.tick_o    (tick),
		.hw_flt_o  (hw_flt),
		.pwm_o     (pwm_o)
	);

	assign led_o       = s.st == ST_FAULT;
	assign reg_rdata_o = s.rdata;

endmodule : srm_drive_seq

// ==== tb/srm_seq_props.sv ====
`timescale 1ns/100ps
module srm_seq_props
	import srm_pkg::*;
(
	// Clock and reset.
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	// Register port.
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [31:0] reg_rdata_o,
	// Panel and power stage.
	input  wire logic        run_stop_i,
	input  wire logic        led_o,
	input  wire logic        hw_oc_i,
	input  wire logic        hw_ov_i,
	input  wire logic [2:0]  pwm_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	// The pin cut has no register in its path, so it must hold at once.
	a_fault_cuts_pwm: assert property (
		(hw_oc_i || hw_ov_i) |-> pwm_o == 3'h0)
		else $error("pwm active during hardware fault");
	// A standing fault must reach the lamp within the fault latency.
	a_lamp_on_fault: assert property (
		(hw_oc_i || hw_ov_i) [*4] |-> led_o)
		else $error("lamp dark during hardware fault");
	// Once the fault state has settled, no phase may be driven.
	a_fault_blanks: assert property (
		led_o [*2] |-> pwm_o == 3'h0)
		else $error("pwm active in fault state");
	// Leaving the fault state needs the switch in its stop position.
	a_exit_at_stop: assert property (
		$fell(led_o) |-> !$past(run_stop_i))
		else $error("fault left with switch at run");
	// Leaving the fault state needs the fault pins quiet.
	a_exit_when_clear: assert property (
		$fell(led_o) |-> !$past(hw_oc_i) && !$past(hw_ov_i))
		else $error("fault left with fault pins active");
	// Status state code and lamp must agree on the fault state.
	a_status_lamp: assert property (
		reg_rd_i && reg_addr_i == REG_STATUS
		|=> (reg_rdata_o[2:0] == 3'h6) == $past(led_o))
		else $error("status state disagrees with lamp");
	// Only one phase at a time, except B with C during alignment.
	a_phase_legal: assert property (
		pwm_o inside {3'b000, 3'b001, 3'b010, 3'b100, 3'b110})
		else $error("illegal phase combination");
	// Read data stand only in the cycle after a read strobe.
	a_rdata_idle: assert property (
		!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside read slot");

	// Main scenarios reached.
	c_fault_seen: cover property ($rose(led_o));
	c_align_seen: cover property (pwm_o == 3'b110);
	c_run_seen: cover property (pwm_o == 3'b001);
endmodule : srm_seq_props

bind srm_drive_seq srm_seq_props u_props (.sys_clk_i, .rstn_i, .reg_addr_i,
	.reg_rd_i, .reg_rdata_o, .run_stop_i, .led_o, .hw_oc_i, .hw_ov_i, .pwm_o);

// ==== tb/srm_motor_model.sv ====
`timescale 1ns/100ps
module srm_motor_model
	import srm_pkg::*;
(
	// Clock and reset.
	input  wire logic          sys_clk_i,
	input  wire logic          rstn_i,
	// Phase drive and levels set by the bench.
	input  wire logic [2:0]    pwm_i,
	input  wire logic [MW-1:0] line_v_i,
	input  wire logic [MW-1:0] dcbus_v_i,
	input  wire logic [MW-1:0] temp_i,
	// Sensed values.
	output srm_meas_t          meas_o
);
	logic [2:0][MW-1:0] cur_q;

	// Winding current rises while driven and decays when released, so the
	// current loop has a real crossing to find instead of a constant.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cur_q <= '0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				if (pwm_i[p] && cur_q[p] < 12'h0800) begin
					cur_q[p] <= cur_q[p] + 12'h0010;
				end else if (!pwm_i[p] && cur_q[p] != 12'h0000) begin
					cur_q[p] <= cur_q[p] - 12'h0010;
				end
			end
		end
	end

	// Supply and temperature follow the bench directly.
	assign meas_o = {line_v_i, dcbus_v_i, temp_i, cur_q};
endmodule : srm_motor_model

// ==== tb/test_sr_motor_drive_sequencer.sv ====
`timescale 1ns/100ps
module test_sr_motor_drive_sequencer;
	import srm_pkg::*;
	localparam int BC = 50;
	localparam int BB = 100;
	localparam int ST = 400;
	localparam logic [8:0] FBIT [4] = '{9'h010, 9'h010, 9'h040, 9'h020};
	localparam logic [MW-1:0] VTAB [4] = '{12'h073, 12'h082, 12'h0E6, 12'h104};
	localparam logic [8:0] STAB [4] = '{9'h002, 9'h086, 9'h102, 9'h186};
	logic          sys_clk_i = 1'b0;
	logic          rstn_i = 1'b0;
	logic [7:0]    reg_addr_i = 8'h00;
	logic [31:0]   reg_wdata_i = 32'h0;
	logic          reg_wr_i = 1'b0;
	logic          reg_rd_i = 1'b0;
	logic [31:0]   reg_rdata_o;
	logic          run_stop_i = 1'b0;
	logic          hw_oc_i = 1'b0;
	logic          hw_ov_i = 1'b0;
	logic          up_i = 1'b0;
	logic          down_i = 1'b0;
	logic          led_o;
	logic [2:0]    pwm_o;
	srm_meas_t     meas_i;
	logic [MW-1:0] line_v = 12'h00E6;
	logic [MW-1:0] dcbus_v = 12'h0300;
	logic [MW-1:0] temp = 12'h0100;
	int            n_fail = 0;
	int            n_compared = 0;

	// Clock at 100 MHz.
	always #5 sys_clk_i = ~sys_clk_i;

	// Device under test with shortened start-up counts.
	srm_drive_seq #(.ALIGN_BC_CYC(BC), .ALIGN_B_CYC(BB), .START_CYC(ST),
		.PWM_CYC(20)) u_dut (.sys_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .run_stop_i, .up_i,
		.down_i, .led_o, .meas_i, .hw_oc_i, .hw_ov_i, .pwm_o);

	// Power stage and motor on the far side.
	srm_motor_model u_motor (.sys_clk_i, .rstn_i, .pwm_i(pwm_o),
		.line_v_i(line_v), .dcbus_v_i(dcbus_v), .temp_i(temp),
		.meas_o(meas_i));

	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	task chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	// Read data are taken in the one cycle where they stand.
	task rd_chk(input string w, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(w, e, reg_rdata_o & m);
	endtask : rd_chk

	task do_reset(input logic [MW-1:0] v);
		@(posedge sys_clk_i);
		rstn_i <= 1'b0;
		line_v <= v;
		repeat (5) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
	endtask : do_reset

	// Manual start; the pwm pattern is timed cycle by cycle.
	task align_run;
		int n_bc;
		int n_b;
		int first_a;
		n_bc = 0;
		n_b = 0;
		first_a = -1;
		@(posedge sys_clk_i) run_stop_i <= 1'b1;
		for (int k = 1; k <= ST + 20; k++) begin
			@(posedge sys_clk_i);
			#1;
			if (pwm_o === 3'b110) n_bc++;
			if (pwm_o === 3'b010) n_b++;
			if (first_a < 0 && pwm_o === 3'b001) first_a = k;
		end
		chk("bc cycles", 32'(BC), 32'(n_bc));
		chk("b hold", 32'h1, 32'(n_b >= BB));
		chk("a start", 32'h1, 32'(first_a >= ST && first_a <= ST + 2));
		rd_chk("run state", REG_STATUS, 32'h7, 32'h5);
	endtask : align_run

	// Cut a hang short well after the expected run length.
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		$display("[ERR] watchdog expected finish seen timeout");
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		rd_chk("status", REG_STATUS, 32'h1FF, 32'h101);
		rd_chk("ctrl", REG_CTRL, 32'h3, 32'h0);
		rd_chk("unmapped", 8'h14, 32'hFFFF_FFFF, 32'h0);
		$display("test reset done");
		align_run();
		wr(REG_CTRL, 32'h1);
		rd_chk("host refused", REG_CTRL, 32'h1, 32'h0);
		@(posedge sys_clk_i) run_stop_i <= 1'b0;
		rd_chk("stopped", REG_STATUS, 32'h7, 32'h1);
		align_run();
		@(posedge sys_clk_i) run_stop_i <= 1'b0;
		$display("test manual start done");
		wr(REG_CTRL, 32'h1);
		rd_chk("host taken", REG_STATUS, 32'h8, 32'h8);
		@(posedge sys_clk_i) run_stop_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		rd_chk("switch ignored", REG_STATUS, 32'h7, 32'h1);
		wr(REG_CTRL, 32'h3);
		rd_chk("host start", REG_STATUS, 32'h7, 32'h2);
		@(posedge sys_clk_i) run_stop_i <= 1'b0;
		wr(REG_CTRL, 32'h0);
		rd_chk("host stop", REG_STATUS, 32'hF, 32'h1);
		$display("test host mode done");
		// Each fault kind but mains in turn, raised in mid-alignment.
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk_i) run_stop_i <= 1'b1;
			repeat (20) @(posedge sys_clk_i);
			case (k)
				0: hw_oc_i <= 1'b1;
				1: hw_ov_i <= 1'b1;
				2: dcbus_v <= 12'h0050;
				default: temp <= 12'h0D00;
			endcase
			repeat (5) @(posedge sys_clk_i);
			#1;
			chk("pwm cut", 32'h0, 32'(pwm_o));
			chk("lamp on", 32'h1, 32'(led_o));
			rd_chk("fault kind", REG_STATUS, 32'h7F, 32'(FBIT[k] | 9'h6));
			hw_oc_i <= 1'b0;
			hw_ov_i <= 1'b0;
			dcbus_v <= 12'h0300;
			temp <= 12'h0100;
			repeat (5) @(posedge sys_clk_i);
			#1;
			chk("lamp held", 32'h1, 32'(led_o));
			run_stop_i <= 1'b0;
			repeat (3) @(posedge sys_clk_i);
			#1;
			chk("lamp off", 32'h0, 32'(led_o));
			rd_chk("fault left", REG_STATUS, 32'h7, 32'h1);
		end
		$display("test faults done");
		// Mains classes at nominal and above the band, one reset each.
		for (int k = 0; k < 4; k++) begin
			do_reset(VTAB[k]);
			@(posedge sys_clk_i) run_stop_i <= 1'b1;
			repeat (3) @(posedge sys_clk_i);
			rd_chk("mains", REG_STATUS, 32'h187, 32'(STAB[k]));
			@(posedge sys_clk_i) run_stop_i <= 1'b0;
		end
		$display("test mains done");
		wrap_up();
	end
endmodule : test_sr_motor_drive_sequencer
